// File: frame_gen_model.sv
// Frame generator model: F-bit and channel-bit strobes, gathers inserted link bits.
// Assumes the transmitter runs on the same clk; one frame lasts ten clocks.
module frame_gen_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clr,
   input  wire logic        dlInsert,
   input  wire logic        dlBit,
   input  wire logic        dl2Insert,
   input  wire logic        dl2Bit,
   output logic             fbitSlot,
   output logic [4:0]       frameIndex,
   output logic             chanSlot,
   output logic [4:0]       chanIndex,
   output logic [2:0]       bitIndex,
   output logic [31:0]      hist,
   output int               dlCnt,
   output int               dl2Cnt,
   output int               dl2Zero,
   output int               maxRun,
   output int               fiveZero,
   output int               badCnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] phase;
   logic       prevDl;
   logic       prevCh;
   int         run;
   // Last slot carries a channel the bench never selects
   assign fbitSlot  = phase == 4'h0;
   assign chanSlot  = phase != 4'h0;
   assign chanIndex = phase == 4'h9 ? 5'h02 : 5'h01;
   assign bitIndex  = 3'(phase - 4'h1);
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      prevDl <= fbitSlot && !frameIndex[0];
      prevCh <= chanSlot;
      if (!rst_n) begin
         phase <= 4'h0;
         frameIndex <= 5'h00;
         hist <= 32'h0;
         badCnt <= 0;
      end else begin
         phase <= phase == 4'h9 ? 4'h0 : phase + 4'h1;
         if (phase == 4'h9) begin
            frameIndex <= frameIndex == 5'h17 ? 5'h00 : frameIndex + 5'h01;
         end
         if ((dlInsert && !prevDl) || (dl2Insert && !prevCh)) begin
            badCnt <= badCnt + 1;
         end
         if (dlInsert) begin
            hist <= {hist[30:0], dlBit};
         end
      end
   end
   ////////////////////////////////////////////////////////////
   // Run lengths expose stuffing and abort octets without decoding frames
   always @(posedge clk) begin
      if (!rst_n || clr) begin
         dlCnt <= 0;
         dl2Cnt <= 0;
         dl2Zero <= 0;
         maxRun <= 0;
         fiveZero <= 0;
         run <= 0;
      end else begin
         dl2Cnt <= dl2Cnt + int'(dl2Insert);
         dl2Zero <= dl2Zero + int'(dl2Insert && !dl2Bit);
         if (dlInsert) begin
            dlCnt <= dlCnt + 1;
            run <= dlBit ? run + 1 : 0;
            if (dlBit && run >= maxRun) maxRun <= run + 1;
            if (!dlBit && run == 5) fiveZero <= fiveZero + 1;
         end
      end
   end
endmodule

// File: t1_esf_hdlc_bom_transmitter.sv
// Two HDLC link transmitters and the bit-oriented message sender of one framer.
// Assumes the frame generator runs on clk and strobes each F-bit and channel bit.
`include "t1_hdlc_tx_cfg.svh"

module t1_esf_hdlc_bom_transmitter #(
   parameter int DEPTH = 128
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [9:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        esfMode,
   input  wire logic        j1Mode,
   input  wire logic        yellowActive,
   input  wire logic        fbitSlot,
   input  wire logic [4:0]  frameIndex,
   input  wire logic        chanSlot,
   input  wire logic [4:0]  chanIndex,
   input  wire logic [2:0]  bitIndex,
   output logic             dlInsert,
   output logic             dlBit,
   output logic             dl2Insert,
   output logic             dl2Bit,
   output logic             intReq_n
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_LEVEL = (AW + 1)'(DEPTH);
   localparam logic [3:0] REPS_LAST = 4'(`MSG_OFF_REPS - 1);
   localparam logic [15:0] IDLE_PAT = `J1_IDLE_PAT;

   function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
      crcStep = (c >> 1) ^ ((c[0] ^ b) ? `CRC_POLY : 16'h0000);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus: one wait cycle, then the access completes

   logic        ack_q;
   logic [7:0]  linkSel_q;
   logic [5:0]  code_q;
   logic [7:0]  l2Chan_q;
   logic [7:0]  l2Bit_q;
   logic [31:0] readdata_q;
   wire  [7:0]  instRead [2];
   wire  [1:0]  irqAny;
   wire  [1:0]  enW;
   wire  [1:0]  bitOut;
   wire  [1:0]  tick;

   wire [7:0] idx   = address[9:2];
   wire       busWr = write & ack_q & byteenable[0];
   wire       inst  = linkSel_q[5:4] != 2'h0;
   wire       posWr = busWr & linkSel_q[`SEL_DIR];
   wire [7:0] topRead =
      (idx == `OFF_LINK_SEL) ? linkSel_q :
      (idx == `OFF_MSG_CODE) ? {2'h0, code_q} :
      (idx == `OFF_L2_CHAN)  ? l2Chan_q :
      (idx == `OFF_L2_BIT)   ? l2Bit_q : instRead[inst];

   assign waitrequest = (read | write) & ~ack_q;
   assign readdata    = readdata_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q      <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= (read | write) & ~ack_q;
         if (read & ~ack_q)
            readdata_q <= {24'h00_0000, topRead};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         linkSel_q <= `LINK_SEL_RST;
         code_q    <= `MSG_CODE_RST;
         l2Chan_q  <= `L2_CHAN_RST;
         l2Bit_q   <= `L2_BIT_RST;
      end else begin
         if (busWr & (idx == `OFF_LINK_SEL)) linkSel_q <= writedata[7:0];
         if (busWr & (idx == `OFF_MSG_CODE)) code_q <= writedata[5:0];
         if (posWr & (idx == `OFF_L2_CHAN)) l2Chan_q <= writedata[7:0];
         if (posWr & (idx == `OFF_L2_BIT)) l2Bit_q <= writedata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit opportunities; frame index 0 is frame 1 of the superframe

   t1_hdlc_tx_pkg::msgMode_type bomMode_q;
   logic [3:0] phase_q;
   logic [3:0] reps_q;

   wire dlTick   = fbitSlot & esfMode & ~frameIndex[0] & ~yellowActive;
   wire parityOk = frameIndex[0] ? l2Chan_q[`L2_EVEN] : l2Chan_q[`L2_ODD];
   wire maskOk   = l2Bit_q[3'h7 - bitIndex];
   assign tick[0] = dlTick & (bomMode_q == t1_hdlc_tx_pkg::MSG_OFF);
   assign tick[1] = chanSlot & esfMode & (chanIndex == l2Chan_q[4:0])
                    & maskOk & parityOk;

   ////////////////////////////////////////////////////////////////////////////////
   // Two transmitter instances

   for (genvar g = 0; g < 2; g++) begin : hd
      localparam logic ME = 1'(g);
      logic [7:0]  ctrl_q;
      logic [6:0]  upper_q;
      logic [6:0]  lower_q;
      logic [3:0]  irqEn_q;
      logic [3:0]  flag_q;
      logic [7:0]  mem_q [DEPTH];
      logic [AW-1:0] wr_q;
      logic [AW-1:0] rd_q;
      logic [AW:0] cnt_q;
      t1_hdlc_tx_pkg::hdlcState_type state_q;
      logic [7:0]  shift_q;
      logic [2:0]  bitCnt_q;
      logic [2:0]  ones_q;
      logic        stuff_q;
      logic        needOpen_q;
      logic [15:0] crc_q;
      logic        lowPrev_q;
      logic        fullPrev_q;

      wire wrHere   = busWr & (inst == ME);
      wire en       = ctrl_q[`CTL_EN];
      wire abort_request      = ctrl_q[`CTL_ABT];
      wire end_of_message      = ctrl_q[`CTL_EOM];
      wire tx       = tick[g] & en;
      // Run count outlives the last stuffed byte, so the check tail is stuffed too
      wire stuffNow = ones_q == 3'h5;
      wire byteEnd  = tx & ~stuffNow & (bitCnt_q == 3'h7);
      wire empty    = cnt_q == '0;
      wire inData   = state_q == t1_hdlc_tx_pkg::ST_DATA;
      wire inIdle   = state_q == t1_hdlc_tx_pkg::ST_IDLE;
      // Thresholds are seven bits; count widened rather than thresholds cut
      wire [7:0] cnt8 = 8'(cnt_q);
      wire startOk  = (cnt8 > {1'b0, upper_q}) | (end_of_message & ~empty);
      wire pop      = byteEnd & ~abort_request & ~empty & (inData | (inIdle & ~needOpen_q & startOk));
      wire closeNow = byteEnd & ~abort_request & inData & empty & end_of_message;
      wire udr      = byteEnd & ~abort_request & inData & empty & ~end_of_message;
      wire fullStat = cnt_q == FULL_LEVEL;
      wire lowStat  = empty | (cnt8 < {1'b0, lower_q});
      wire dataWr   = wrHere & (idx == `OFF_DATA);
      wire push     = dataWr & en & ~fullStat;
      wire ovr      = dataWr & fullStat;
      wire flush    = ctrl_q[`CTL_CLR] | (byteEnd & abort_request);
      wire [15:0] crcNext = crcStep(crc_q, shift_q[0]);
      wire [3:0] flagSet = {fullStat & ~fullPrev_q, ovr, udr, lowStat & ~lowPrev_q};
      wire [3:0] flagClr = (wrHere & (idx == `OFF_STATUS)) ? writedata[3:0] : 4'h0;

      assign enW[g]      = en;
      assign bitOut[g]   = en ? (stuffNow ? 1'b0 : shift_q[0]) : 1'b1;
      assign irqAny[g]   = |(flag_q & irqEn_q);
      assign instRead[g] =
         (idx == `OFF_CTRL)   ? ctrl_q :
         (idx == `OFF_UPPER)  ? {1'b0, upper_q} :
         (idx == `OFF_LOWER)  ? {1'b0, lower_q} :
         (idx == `OFF_IRQ_EN) ? {4'h0, irqEn_q} :
         (idx == `OFF_STATUS) ? {1'b0, fullStat, lowStat, 1'b0, flag_q} : 8'h00;

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            ctrl_q     <= `CTRL_RST;
            upper_q    <= `UPPER_RST;
            lower_q    <= `LOWER_RST;
            irqEn_q    <= `IRQ_EN_RST;
            flag_q     <= 4'h0;
            lowPrev_q  <= 1'b1;                                           // Empty after reset: no false edge
            fullPrev_q <= 1'b0;
         end else begin
            if (wrHere & (idx == `OFF_CTRL)) begin
               ctrl_q <= writedata[7:0];
            end else begin
               ctrl_q[`CTL_CLR] <= 1'b0;
               if (closeNow) ctrl_q[`CTL_EOM] <= 1'b0;
            end
            if (wrHere & (idx == `OFF_UPPER)) upper_q <= writedata[6:0];
            if (wrHere & (idx == `OFF_LOWER)) lower_q <= writedata[6:0];
            if (wrHere & (idx == `OFF_IRQ_EN)) irqEn_q <= writedata[3:0];
            // A set in the clearing cycle survives
            flag_q     <= (flag_q & ~flagClr) | flagSet;
            lowPrev_q  <= lowStat;
            fullPrev_q <= fullStat;
         end
      end

      always_ff @(posedge clk) begin
         if (!rst_n || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
         end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
         end
      end

      always_ff @(posedge clk) begin
         if (push) mem_q[wr_q] <= writedata[7:0];
      end

      // Disabled instance is held in its idle state
      always_ff @(posedge clk) begin
         if (!rst_n || !en) begin
            state_q    <= t1_hdlc_tx_pkg::ST_IDLE;
            shift_q    <= `FLAG_OCTET;
            bitCnt_q   <= 3'h0;
            ones_q     <= 3'h0;
            stuff_q    <= 1'b0;
            needOpen_q <= 1'b0;
            crc_q      <= `CRC_INIT;
         end else if (tx && stuffNow) begin
            ones_q <= 3'h0;
         end else if (tx) begin
            ones_q   <= (stuff_q & shift_q[0]) ? ones_q + 3'h1 : 3'h0;
            bitCnt_q <= bitCnt_q + 3'h1;
            shift_q  <= {1'b1, shift_q[7:1]};
            if (inData) crc_q <= crcNext;
            if (bitCnt_q == 3'h7) begin
               stuff_q <= 1'b0;
               case (state_q)
                  t1_hdlc_tx_pkg::ST_IDLE: begin
                     shift_q    <= `FLAG_OCTET;
                     needOpen_q <= 1'b0;
                     if (!needOpen_q && startOk) begin
                        state_q <= t1_hdlc_tx_pkg::ST_DATA;
                        shift_q <= mem_q[rd_q];
                        stuff_q <= 1'b1;
                        crc_q   <= `CRC_INIT;
                     end
                  end
                  t1_hdlc_tx_pkg::ST_DATA: begin
                     if (!empty) begin
                        shift_q <= mem_q[rd_q];
                        stuff_q <= 1'b1;
                     end else if (end_of_message && ctrl_q[`CTL_CRC]) begin
                        state_q <= t1_hdlc_tx_pkg::ST_FCS1;
                        shift_q <= ~crcNext[7:0];
                        stuff_q <= 1'b1;
                     end else if (end_of_message) begin
                        state_q    <= t1_hdlc_tx_pkg::ST_IDLE;
                        shift_q    <= `FLAG_OCTET;
                        needOpen_q <= ~ctrl_q[`CTL_SHARE];
                     end else begin
                        // Underrun kills the frame rather than sending junk
                        state_q <= t1_hdlc_tx_pkg::ST_IDLE;
                        shift_q <= `ABORT_OCTET;
                     end
                  end
                  t1_hdlc_tx_pkg::ST_FCS1: begin
                     state_q <= t1_hdlc_tx_pkg::ST_FCS2;
                     shift_q <= ~crc_q[15:8];
                     stuff_q <= 1'b1;
                  end
                  t1_hdlc_tx_pkg::ST_FCS2: begin
                     state_q    <= t1_hdlc_tx_pkg::ST_IDLE;
                     shift_q    <= `FLAG_OCTET;
                     needOpen_q <= ~ctrl_q[`CTL_SHARE];
                  end
                  default: begin
                     state_q <= t1_hdlc_tx_pkg::ST_IDLE;
                     shift_q <= `FLAG_OCTET;
                  end
               endcase
               if (abort_request) begin
                  state_q <= t1_hdlc_tx_pkg::ST_ABORT;
                  shift_q <= `ABORT_OCTET;
                  stuff_q <= 1'b0;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit-oriented message; phase also paces the idle pattern

   wire        codeOn   = code_q != `MSG_IDLE_CODE;
   wire        boundary = dlTick & (phase_q == 4'hF);
   wire [15:0] offPat   = j1Mode ? `J1_OFF_PAT : `T1_OFF_PAT;
   wire [15:0] msgWord  = (bomMode_q == t1_hdlc_tx_pkg::MSG_ON) ?
                          {`MSG_PREAMBLE, 1'b0, code_q, 1'b0} : offPat;
   wire        msgBit   = msgWord[4'hF - phase_q];
   wire        idleBit  = j1Mode ? IDLE_PAT[4'hF - phase_q] : 1'b1;
   wire        dlBitD   = (bomMode_q != t1_hdlc_tx_pkg::MSG_OFF) ? msgBit :
                          enW[0] ? bitOut[0] : idleBit;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bomMode_q <= t1_hdlc_tx_pkg::MSG_OFF;
         phase_q   <= 4'h0;
         reps_q    <= 4'h0;
      end else begin
         if (dlTick) phase_q <= phase_q + 4'h1;
         case (bomMode_q)
            t1_hdlc_tx_pkg::MSG_OFF:
               if (boundary && codeOn) bomMode_q <= t1_hdlc_tx_pkg::MSG_ON;
            t1_hdlc_tx_pkg::MSG_ON:
               if (boundary && !codeOn) begin
                  bomMode_q <= t1_hdlc_tx_pkg::MSG_DISABLE;
                  reps_q    <= 4'h0;
               end
            t1_hdlc_tx_pkg::MSG_DISABLE:
               if (boundary && codeOn) bomMode_q <= t1_hdlc_tx_pkg::MSG_ON;
               else if (boundary && reps_q == REPS_LAST) bomMode_q <= t1_hdlc_tx_pkg::MSG_OFF;
               else if (boundary) reps_q <= reps_q + 4'h1;
            default: bomMode_q <= t1_hdlc_tx_pkg::MSG_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dlInsert  <= 1'b0;
         dlBit     <= 1'b1;
         dl2Insert <= 1'b0;
         dl2Bit    <= 1'b1;
         intReq_n  <= 1'b1;
      end else begin
         dlInsert  <= dlTick;
         dlBit     <= dlBitD;
         dl2Insert <= tick[1];
         dl2Bit    <= bitOut[1];
         intReq_n  <= ~|irqAny;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_clrWrite;
      busWr && idx == `OFF_CTRL && writedata[`CTL_CLR] && !inst;
   endsequence

   a_sf_no_link: assert property (fbitSlot && !esfMode |=> !dlInsert)
      else $error("data-link bit taken in SF format");
   a_select_reach: assert property (busWr && idx == `OFF_UPPER && inst
      |=> hd[1].upper_q == $past(writedata[6:0]) && $stable(hd[0].upper_q))
      else $error("write reached the wrong transmitter");
   a_dl_position: assert property (dlInsert |-> $past(fbitSlot) && !$past(frameIndex[0])
      && !$past(yellowActive))
      else $error("data-link bit outside odd-frame F-bit");
   a_chan_position: assert property (dl2Insert |-> $past(chanSlot)
      && $past(chanIndex) == $past(l2Chan_q[4:0]))
      else $error("second link outside its channel");
   a_disabled_ones: assert property (tick[1] && !hd[1].en |=> dl2Bit)
      else $error("disabled transmitter sent a zero");
   a_stuff_zero: assert property (tick[0] && hd[0].en && hd[0].stuffNow |=> !dlBit)
      else $error("no zero after five ones");
   a_abort_load: assert property (hd[0].byteEnd && hd[0].abort_request
      |=> hd[0].state_q == t1_hdlc_tx_pkg::ST_ABORT && hd[0].shift_q == `ABORT_OCTET
      && hd[0].cnt_q == '0)
      else $error("abort did not flush and load abort octet");
   a_flush_any: assert property (s_clrWrite ##1 1'b1 |=> hd[0].cnt_q == '0)
      else $error("flush left data in FIFO");
   a_full_flag: assert property ($rose(hd[0].fullStat) |=> hd[0].flag_q[3])
      else $error("full flag not latched");
   a_msg_priority: assert property (dlTick && bomMode_q != t1_hdlc_tx_pkg::MSG_OFF
      |=> dlBit == $past(msgBit))
      else $error("message bit displaced");
   a_yellow_first: assert property (fbitSlot && yellowActive |=> !dlInsert)
      else $error("data-link bit taken during yellow alarm");
endmodule

// File: t1_esf_hdlc_bom_transmitter_bench.sv
// Self-checking bench: Avalon-MM register access plus link bits seen by the model.
// Assumes a 200 MHz clk and the FIFO depth shrunk to eight bytes.
module t1_esf_hdlc_bom_transmitter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic        esfMode = 1'b1;
   logic        yellowActive = 1'b0;
   logic        j1Mode = 1'b0;
   logic        clr = 1'b0;
   logic [9:0]  address = 10'h000;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, hist;
   logic [7:0]  rv;
   logic [15:0] msgWord;
   logic        found, waitrequest, fbitSlot, chanSlot, dlInsert, dlBit, dl2Insert, dl2Bit;
   logic        intReq_n;
   logic [4:0]  frameIndex, chanIndex;
   logic [2:0]  bitIndex;
   logic [7:0]  regIdx [7] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h5D, 8'h10, 8'h39};
   logic [7:0]  regRst [7] = '{8'h00, 8'h40, 8'h20, 8'h00, 8'h3F, 8'h00, 8'h00};
   int          dlCnt, dl2Cnt, dl2Zero, maxRun, fiveZero, badCnt;
   int          errors = 0;
   int          checksDone = 0;

   always #2.5 clk = ~clk;
   t1_esf_hdlc_bom_transmitter #(.DEPTH(8)) t1_esf_hdlc_bom_transmitter_i (
      .clk, .rst_n, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
      .waitrequest, .esfMode, .j1Mode, .yellowActive, .fbitSlot, .frameIndex,
      .chanSlot, .chanIndex, .bitIndex, .dlInsert, .dlBit, .dl2Insert, .dl2Bit, .intReq_n);
   frame_gen_model frame_gen_model_i (
      .clk, .rst_n, .clr, .dlInsert, .dlBit, .dl2Insert, .dl2Bit, .fbitSlot, .frameIndex,
      .chanSlot, .chanIndex, .bitIndex, .hist, .dlCnt, .dl2Cnt, .dl2Zero, .maxRun,
      .fiveZero, .badCnt);
   ////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d checks %0d", errors, checksDone);
      if (errors == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held to the edge that samples waitrequest low; released there
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= {idx, 2'b00};
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      chk({31'h0, waitrequest}, 32'h0);
      rv = readdata[7:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(32'(rv), 32'(exp));
   endtask
   task automatic clear_stats;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Any rotation of a flag stream has period eight with six ones
   task automatic flags_chk;
      chk(32'(hist[7:0] == hist[15:8] && $countones(hist[7:0]) == 6), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (regIdx[i]) rd(regIdx[i], regRst[i]);
      wr(8'h0D, 8'h10);
      wr(8'h70, 8'h41);
      rd(8'h70, 8'h00);
      wr(8'h0D, 8'h18);
      wr(8'h70, 8'h41);
      wr(8'h71, 8'h80);
      rd(8'h70, 8'h41);
      clear_stats;
      wait_cyc(240);
      chk(dl2Cnt, 12);
      chk(dl2Zero, 0);
      chk(dlCnt, 12);
      chk(32'(hist[11:0]), 32'hFFF);
      @(posedge clk);
      j1Mode <= 1'b1;
      wait_cyc(480);
      flags_chk;
      @(posedge clk);
      j1Mode <= 1'b0;
      yellowActive <= 1'b1;
      clear_stats;
      wait_cyc(240);
      chk(dlCnt, 0);
      @(posedge clk);
      yellowActive <= 1'b0;
      esfMode <= 1'b0;
      clear_stats;
      wait_cyc(240);
      chk(dlCnt + dl2Cnt, 0);
      @(posedge clk);
      esfMode <= 1'b1;
      wr(8'h0D, 8'h08);
      wr(8'h34, 8'h01);
      wr(8'h0D, 8'h18);
      rd(8'h34, 8'h00);
      wr(8'h35, 8'h30);
      wr(8'h0D, 8'h08);
      rd(8'h34, 8'h01);
      rd(8'h35, 8'h40);
      wait_cyc(480);
      flags_chk;
      clear_stats;
      repeat (3) wr(8'h39, 8'hFF);
      wr(8'h34, 8'h0B);
      wait_cyc(2000);
      chk(32'(fiveZero > 0), 32'h1);
      chk(maxRun, 6);
      flags_chk;
      clear_stats;
      wr(8'h34, 8'h05);
      wait_cyc(800);
      chk(maxRun, 7);
      wr(8'h34, 8'h01);
      wr(8'h35, 8'h7F);
      repeat (9) wr(8'h39, 8'h55);
      bus(1'b0, 8'h38, 8'h00);
      chk(32'(rv & 8'h4C), 32'h4C);
      wr(8'h37, 8'h04);
      wait_cyc(3);
      chk(32'(intReq_n), 32'h0);
      wr(8'h38, 8'h0F);
      wait_cyc(3);
      chk(32'(intReq_n), 32'h1);
      wr(8'h34, 8'h41);
      bus(1'b0, 8'h38, 8'h00);
      chk(32'(rv & 8'h68), 32'h20);
      wr(8'h37, 8'h00);
      msgWord = {8'hFF, 1'b0, 6'h12, 1'b0};
      wr(8'h5D, 8'h12);
      wait_cyc(1600);
      found = 1'b0;
      for (int r = 0; r < 16; r++) found |= hist[15:0] == 16'({msgWord, msgWord} >> r);
      chk(32'(found && hist[31:16] == hist[15:0]), 32'h1);
      wr(8'h5D, 8'h3F);
      wait_cyc(960);
      chk(hist, 32'hFFFFFFFF);
      wait_cyc(6000);
      flags_chk;
      chk(badCnt, 0);
      end_sim;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      end_sim;
   end
endmodule

// File: t1_hdlc_tx_cfg.svh
// Offsets, field positions, reset values and pattern constants of the transmitter.
// Assumes register indices are word indices; byte address is four times the index.
`ifndef T1_HDLC_TX_CFG_SVH
`define T1_HDLC_TX_CFG_SVH

`define OFF_LINK_SEL   8'h0D
`define OFF_CTRL       8'h34
`define OFF_UPPER      8'h35
`define OFF_LOWER      8'h36
`define OFF_IRQ_EN     8'h37
`define OFF_STATUS     8'h38
`define OFF_DATA       8'h39
`define OFF_MSG_CODE   8'h5D
`define OFF_L2_CHAN    8'h70
`define OFF_L2_BIT     8'h71

`define SEL_DIR        3
`define CTL_EN         0
`define CTL_CRC        1
`define CTL_ABT        2
`define CTL_EOM        3
`define CTL_CLR        6
`define CTL_SHARE      7
`define STS_FULL       6
`define STS_LOW        5
`define L2_EVEN        7
`define L2_ODD         6

`define LINK_SEL_RST   8'h00
`define CTRL_RST       8'h00
`define UPPER_RST      7'h40
`define LOWER_RST      7'h20
`define IRQ_EN_RST     4'h0
`define MSG_CODE_RST   6'h3F
`define L2_CHAN_RST    8'h00
`define L2_BIT_RST     8'h00

`define FLAG_OCTET     8'h7E
`define ABORT_OCTET    8'h7F
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'h8408
`define MSG_IDLE_CODE  6'h3F
`define MSG_PREAMBLE   8'hFF
`define T1_OFF_PAT     16'hFFFF
`define J1_OFF_PAT     16'hFF7E
`define J1_IDLE_PAT    16'h7E7E
`define MSG_OFF_REPS   16

`endif

// File: t1_hdlc_tx_pkg.sv
// Types shared by the data-link transmitter.
// Assumes nothing beyond a SystemVerilog compiler.
package t1_hdlc_tx_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DATA  = 3'h1,
      ST_FCS1  = 3'h3,
      ST_FCS2  = 3'h2,
      ST_ABORT = 3'h6
   } hdlcState_type;
   typedef enum logic [1:0] {
      MSG_OFF     = 2'h0,
      MSG_ON      = 2'h1,
      MSG_DISABLE = 2'h3
   } msgMode_type;
endpackage
